// >>> rtl/fan_drive_duty_limits_freq.sv
// duty limit, idle floor and low-frequency pwm logic for four fan-drive outputs
// Behaviour
// - auto idle: out c 0% or minimum
// - auto idle: out d 0% or minimum
// - bits 4:2 pick out c rate
// - bits 7:5 pick out d rate
// - four minimum duty registers, default 0x80
// - shared maximum duty register, default 0xC0
// - config resets 0x90, obeys register lock
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fan_limits_consts.svh"
module fan_drive_duty_limits_freq #(
	parameter int ADDR_W = 12
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire fan_limits_pkg::demand_type demand_a,
	input  wire fan_limits_pkg::demand_type demand_b,
	input  wire fan_limits_pkg::demand_type demand_c,
	input  wire fan_limits_pkg::demand_type demand_d,
	output logic                            fan_drive_out_a,
	output logic                            fan_drive_out_b,
	output logic                            fan_drive_out_c,
	output logic                            fan_drive_out_d
);
	import fan_limits_pkg::*;

	// pwm rate for each rate code, in tenths of a hertz
	// step count = clk * 10 / (rate * 256), rate given in tenths of a hertz
	localparam int RATE_X10 [8] = '{110, 147, 221, 294, 353, 441, 588, 882};

	// register storage
	logic [7:0] cd_cfg_ff;                 // floors and rates for c and d
	logic [7:0] min_ff [4];                // per-output minimum duty
	logic [7:0] max_ff;                    // shared maximum duty
	logic       auto_ff;                   // automatic control mode
	logic       lock_ff;                   // register lock, sticky until reset
	logic [7:0] duty_ff [4];               // commanded duty after limits

	// write channel capture
	logic       aw_hold_ff;                // address taken, waiting for data
	logic       w_hold_ff;                 // data taken, waiting for address
	wr_req_type wr_ff;                     // captured write
	logic       do_wr;                     // both halves present
	logic [9:0] wr_idx;                    // word index of write
	logic       soft_rst;                  // software reset request

	// bvalid still up means the last response is unanswered: hold the next write back
	assign do_wr  = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign wr_idx = wr_ff.addr[11:2];
	assign soft_rst = do_wr && wr_idx == 10'(`IDX_CTRL) && wr_ff.strb[0]
		&& wr_ff.data[`CTRL_SWRST_BIT];

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff    <= 1'b0;
			w_hold_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			wr_ff         <= '0;
		end else begin
			s_axi_awready <= !aw_hold_ff && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_ff && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff    <= 1'b1;
				wr_ff.addr    <= 32'(s_axi_awaddr);
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff    <= 1'b1;
				wr_ff.data   <= s_axi_wdata;
				wr_ff.strb   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff  <= 1'b0;
			end
		end
	end

	// write response, okay always; locked writes are dropped silently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= 2'b00;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// limit registers: power-on and software reset defaults, lock blocks writes
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			cd_cfg_ff <= `RST_CD_CFG;
			for (int i = 0; i < 4; i++) begin
				min_ff[i] <= `RST_MIN_DUTY;
			end
			max_ff <= `RST_MAX_DUTY;
		end else if (do_wr && wr_ff.strb[0] && !lock_ff) begin
			// locked registers ignore writes until reset
			case (wr_idx)
				10'(`IDX_CD_CFG):   cd_cfg_ff <= wr_ff.data[7:0];
				10'(`IDX_A_MIN):    min_ff[0] <= wr_ff.data[7:0];
				10'(`IDX_B_MIN):    min_ff[1] <= wr_ff.data[7:0];
				10'(`IDX_C_MIN):    min_ff[2] <= wr_ff.data[7:0];
				10'(`IDX_D_MIN):    min_ff[3] <= wr_ff.data[7:0];
				10'(`IDX_MAX_DUTY): max_ff    <= wr_ff.data[7:0];
				default: ;
			endcase
		end
	end

	// control: lock only clears on a reset, software reset clears mode
	// lock survives a software reset on purpose, so firmware cannot unlock itself
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			auto_ff <= 1'b0;
			lock_ff <= !aresetn ? 1'b0 : lock_ff;
		end else if (do_wr && wr_ff.strb[0] && wr_idx == 10'(`IDX_CTRL)) begin
			auto_ff <= wr_ff.data[`CTRL_AUTO_BIT];
			lock_ff <= lock_ff | wr_ff.data[`CTRL_LOCK_BIT];
		end
	end

	// read channel: one cycle to answer, held until taken
	// arready toggles while idle; a master holding arvalid is taken within two edges
	rd_state_type rd_state_ff;
	logic [9:0]   rd_idx;
	logic [31:0]  rd_word;
	assign rd_idx = s_axi_araddr[11:2];

	// read decode
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			10'(`IDX_CD_CFG):   rd_word[7:0] = cd_cfg_ff;
			10'(`IDX_A_MIN):    rd_word[7:0] = min_ff[0];
			10'(`IDX_B_MIN):    rd_word[7:0] = min_ff[1];
			10'(`IDX_C_MIN):    rd_word[7:0] = min_ff[2];
			10'(`IDX_D_MIN):    rd_word[7:0] = min_ff[3];
			10'(`IDX_MAX_DUTY): rd_word[7:0] = max_ff;
			10'(`IDX_CTRL):     rd_word[1:0] = {lock_ff, auto_ff};
			10'(`IDX_DUTY_AB):  rd_word[15:0] = {duty_ff[1], duty_ff[0]};
			10'(`IDX_DUTY_CD):  rd_word[15:0] = {duty_ff[3], duty_ff[2]};
			10'(`IDX_STATUS):   rd_word[3:0] = {fan_drive_out_d, fan_drive_out_c,
				fan_drive_out_b, fan_drive_out_a};
			default:            rd_word = 32'h0000_0000;
		endcase
	end

	// read state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_ff   <= RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			case (rd_state_ff)
				RD_IDLE: begin
					s_axi_arready <= !s_axi_arready;
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= 2'b00;
						rd_state_ff   <= RD_RESP;
					end
				end
				RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_ff  <= RD_IDLE;
					end
				end
				default: rd_state_ff <= RD_IDLE;
			endcase
		end
	end

	// duty limits, one lane per output
	demand_type dem [4];
	logic       floor_sel [4];
	assign dem[0] = demand_a;
	assign dem[1] = demand_b;
	assign dem[2] = demand_c;
	assign dem[3] = demand_d;
	// outputs a and b have their floor bits elsewhere: treat as off below idle
	assign floor_sel[0] = 1'b0;
	assign floor_sel[1] = 1'b0;
	assign floor_sel[2] = cd_cfg_ff[`CFG_FLOOR_C_BIT];
	assign floor_sel[3] = cd_cfg_ff[`CFG_FLOOR_D_BIT];

	// limit the commanded duty; manual mode passes the demand straight through
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				duty_ff[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!auto_ff) begin
					duty_ff[i] <= dem[i].duty;
				end else if (dem[i].below_idle) begin
					// idle floor: off or minimum
					duty_ff[i] <= floor_sel[i] ? min_ff[i] : 8'h00;
				end else if (dem[i].duty < min_ff[i]) begin
					duty_ff[i] <= min_ff[i];
				end else if (dem[i].duty > max_ff) begin
					duty_ff[i] <= max_ff;
				end else begin
					duty_ff[i] <= dem[i].duty;
				end
			end
		end
	end

	// low-frequency pwm for c and d at the chosen rate; a and b at the default rate
	logic [2:0]  rate_code [4];
	logic [19:0] step_len  [4];
	logic [19:0] div_ff    [4];            // divider toward one pwm step
	logic [7:0]  phase_ff  [4];            // position within the 256-step period
	logic        out_ff    [4];
	assign rate_code[0] = 3'b100;
	assign rate_code[1] = 3'b100;
	assign rate_code[2] = cd_cfg_ff[`CFG_RATE_C_LO +: 3];
	assign rate_code[3] = cd_cfg_ff[`CFG_RATE_D_LO +: 3];

	// step length lookup, rounded down so the rate is never slow
	// the divisor is constant per code, so this folds into an eight-entry table
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			step_len[i] = 20'((`CLK_HZ * 10) / (RATE_X10[rate_code[i]] * `PWM_STEPS));
		end
	end

	// step enable pulses and the phase counter; output high while phase is below duty
	// duty 0 never drives high; duty 0xff still leaves one low step in 256
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				div_ff[i]   <= 20'h0_0000;
				phase_ff[i] <= 8'h00;
				out_ff[i]   <= 1'b0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (div_ff[i] + 20'd1 >= step_len[i]) begin
					div_ff[i]   <= 20'h0_0000;
					phase_ff[i] <= phase_ff[i] + 8'd1;
				end else begin
					div_ff[i] <= div_ff[i] + 20'd1;
				end
				out_ff[i] <= phase_ff[i] < duty_ff[i];
			end
		end
	end

	// registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fan_drive_out_a <= 1'b0;
			fan_drive_out_b <= 1'b0;
			fan_drive_out_c <= 1'b0;
			fan_drive_out_d <= 1'b0;
		end else begin
			fan_drive_out_a <= out_ff[0];
			fan_drive_out_b <= out_ff[1];
			fan_drive_out_c <= out_ff[2];
			fan_drive_out_d <= out_ff[3];
		end
	end

	// checks; assertions on reset values, lock, idle floors, clamps and step lengths, then covers
	// expected step length per rate code: 25 MHz over rate times 256, rounded down
	localparam int STEP_TAB [8] = '{8877, 6643, 4418, 3321, 2766, 2214, 1660, 1107};
	a_cfg_reset_val: assert property (@(posedge aclk) !aresetn |=> cd_cfg_ff == 8'h90)
		else $error("config not 0x90 after reset");
	a_min_reset_val: assert property (@(posedge aclk) !aresetn |=> min_ff[2] == 8'h80)
		else $error("minimum not 0x80 after reset");
	a_max_reset_val: assert property (@(posedge aclk) !aresetn |=> max_ff == 8'hC0)
		else $error("maximum not 0xC0 after reset");
	// a locked register must not move unless a software reset restores it
	a_lock_holds_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_ff && !soft_rst |=> $stable(cd_cfg_ff))
		else $error("locked config changed");
	a_lock_holds_lim: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_ff && !soft_rst |=> $stable(min_ff[3]) && $stable(max_ff))
		else $error("locked limit changed");
	// idle floor: the duty one cycle later follows the floor bit of that cycle
	a_idle_c_floor: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_ff && demand_c.below_idle
		|=> duty_ff[2] == ($past(cd_cfg_ff[0]) ? $past(min_ff[2]) : 8'h00))
		else $error("out c idle duty wrong");
	a_idle_d_floor: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_ff && demand_d.below_idle
		|=> duty_ff[3] == ($past(cd_cfg_ff[1]) ? $past(min_ff[3]) : 8'h00))
		else $error("out d idle duty wrong");
	// limits are taken as they stood when the duty was computed, so a limit
	// write landing in that same cycle cannot look like a clamp failure
	a_run_clamp_c: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_ff && !demand_c.below_idle && min_ff[2] <= max_ff
		|=> duty_ff[2] >= $past(min_ff[2]) && duty_ff[2] <= $past(max_ff))
		else $error("out c duty outside limits");
	a_run_clamp_d: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_ff && !demand_d.below_idle && min_ff[3] <= max_ff
		|=> duty_ff[3] >= $past(min_ff[3]) && duty_ff[3] <= $past(max_ff))
		else $error("out d duty outside limits");
	// step length against the hand-worked table, not the divider's own formula
	a_rate_c_step: assert property (@(posedge aclk) disable iff (!aresetn)
		step_len[2] == 20'(STEP_TAB[cd_cfg_ff[4:2]]))
		else $error("out c step length wrong");
	a_rate_d_step: assert property (@(posedge aclk) disable iff (!aresetn)
		step_len[3] == 20'(STEP_TAB[cd_cfg_ff[7:5]]))
		else $error("out d step length wrong");
	// main scenarios: bus traffic, idle floors, clamp at the maximum
	c_write_done: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	c_read_done:  cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_idle_floor: cover property (@(posedge aclk) auto_ff && demand_c.below_idle && cd_cfg_ff[0]);
	c_floor_d:    cover property (@(posedge aclk) auto_ff && demand_d.below_idle && cd_cfg_ff[1]);
	c_max_clamp:  cover property (@(posedge aclk) auto_ff && demand_d.duty > max_ff);
endmodule

// >>> include/fan_limits_consts.svh
// offsets, field positions, reset values and timing counts for the fan limit block
`ifndef FAN_LIMITS_CONSTS_SVH
`define FAN_LIMITS_CONSTS_SVH
// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define IDX_CD_CFG        8'h26
`define IDX_A_MIN         8'h28
`define IDX_B_MIN         8'h29
`define IDX_C_MIN         8'h2A
`define IDX_D_MIN         8'h2B
`define IDX_MAX_DUTY      8'h2C
// own registers: control (auto, lock, software reset bits), duty readback for a/b and c/d, status
`define IDX_CTRL          8'h40
`define IDX_DUTY_AB       8'h41
`define IDX_DUTY_CD       8'h42
`define IDX_STATUS        8'h43
// configuration field positions
`define CFG_FLOOR_C_BIT   0
`define CFG_FLOOR_D_BIT   1
`define CFG_RATE_C_LO     2
`define CFG_RATE_D_LO     5
// control register bits
`define CTRL_AUTO_BIT     0
`define CTRL_LOCK_BIT     1
`define CTRL_SWRST_BIT    2
// reset values
`define RST_CD_CFG        8'h90
`define RST_MIN_DUTY      8'h80
`define RST_MAX_DUTY      8'hC0
// timing: clock and pwm period steps
`define CLK_HZ            25000000
`define PWM_STEPS         256
`endif

// >>> include/fan_limits_pkg.sv
// types shared by the fan limit block
package fan_limits_pkg;
	// axi4-lite write request bundle
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_type;
	// per-output duty demand from the control loop
	typedef struct packed {
		logic       below_idle;
		logic [7:0] duty;
	} demand_type;
	// read state machine
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_type;
endpackage

// >>> verification/fan_load_model.sv
// fan load model: times the first full high pulse seen on a drive pin
`timescale 1ns/1ps
module fan_load_model (
	input  wire logic        aclk,
	input  wire logic        drive,
	output logic [31:0]      high_len,
	output logic             pulse_seen
);
	logic [31:0] run_ff; // cycles high so far
	initial begin
		run_ff = 0;
		high_len = 0;
		pulse_seen = 0;
	end
	// a fan only sees its pin; only the first pulse is kept, later ones are ignored
	always @(posedge aclk) begin
		if (drive === 1'b1) begin
			run_ff <= run_ff + 1;
		end else begin
			if (run_ff != 0 && !pulse_seen) begin
				high_len <= run_ff;
				pulse_seen <= 1'b1;
			end
			run_ff <= 0;
		end
	end
endmodule

// >>> verification/fan_drive_duty_limits_freq_tb.sv
// self-checking bench for the fan duty limit block
`timescale 1ns/1ps
`include "fan_limits_consts.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, got, exp); end end
module fan_drive_duty_limits_freq_tb;
	import fan_limits_pkg::*;
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	demand_type  dem_a, dem_b, dem_c, dem_d;
	logic        out_a, out_b, out_c, out_d;
	logic [31:0] len_c, len_d;   // high pulse widths seen by the fans
	logic        seen_c, seen_d;
	int          err_count = 0;
	int          tests_run = 0;
	logic [31:0] rv;             // last read word
	logic [1:0]  resp;           // last write response
	logic [1:0]  rresp_last;     // last read response
	fan_drive_duty_limits_freq dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .demand_a(dem_a),
		.demand_b(dem_b), .demand_c(dem_c), .demand_d(dem_d), .fan_drive_out_a(out_a),
		.fan_drive_out_b(out_b), .fan_drive_out_c(out_c), .fan_drive_out_d(out_d));
	fan_load_model fan_c_u (.aclk(aclk), .drive(out_c), .high_len(len_c), .pulse_seen(seen_c));
	fan_load_model fan_d_u (.aclk(aclk), .drive(out_d), .high_len(len_d), .pulse_seen(seen_d));
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	// register write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		@(posedge aclk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h0000_00, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_d = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_d = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	// register read; the watchdog bounds every wait
	task automatic rd(input logic [7:0] idx);
		@(posedge aclk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rresp_last = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		rd(idx);
		`CHK(rv, exp)
		`CHK(rresp_last, 2'b00)
	endtask
	// first pulse after reset at default rate code 100: width is duty steps
	task automatic pulse_width();
		int step;
		step = 250000000 / (353 * 256);
		wait (seen_c && seen_d);
		`CHK((len_c + 8 >= 2 * step) && (len_c <= 2 * step + 8), 1'b1)
		`CHK((len_d + 8 >= 4 * step) && (len_d <= 4 * step + 8), 1'b1)
	endtask
	task automatic reset_values();
		rchk(`IDX_CD_CFG, 32'h0000_0090);
		for (int i = 0; i < 4; i++) rchk(8'(`IDX_A_MIN + i), 32'h0000_0080);
		rchk(`IDX_MAX_DUTY, 32'h0000_00C0);
		rchk(8'h3F, 32'h0000_0000);
		// outputs a and b have zero demand here, so their pins and status bits stay low
		rd(`IDX_STATUS);
		`CHK(rv[1:0], 2'b00)
		`CHK({out_a, out_b}, 2'b00)
	endtask
	// every rate code in each field, the other field holding the mirror code
	task automatic rate_codes();
		for (int k = 0; k < 8; k++) begin
			wr(`IDX_CD_CFG, {k[2:0], 3'(7 - k), 2'b00});
			rchk(`IDX_CD_CFG, {24'h0000_00, k[2:0], 3'(7 - k), 2'b00});
		end
	endtask
	// auto mode clamps demand into min..max, boundary value passes unchanged
	task automatic clamp();
		wr(`IDX_A_MIN, 8'h20);
		wr(`IDX_B_MIN, 8'h30);
		wr(`IDX_C_MIN, 8'h35);
		wr(`IDX_D_MIN, 8'h46);
		wr(`IDX_MAX_DUTY, 8'hA0);
		rchk(`IDX_MAX_DUTY, 32'h0000_00A0);
		wr(`IDX_CTRL, 8'h01);
		dem_a <= '{1'b0, 8'h10};
		dem_b <= '{1'b0, 8'hF0};
		dem_c <= '{1'b0, 8'h35};
		dem_d <= '{1'b0, 8'hA1};
		rd(`IDX_DUTY_AB);
		`CHK(rv[15:0], 16'hA0_20)
		rd(`IDX_DUTY_CD);
		`CHK(rv[15:0], 16'hA0_35)
	endtask
	// below idle: c and d give 0 or their minimum per floor bit, a and b give 0
	task automatic idle_floor();
		dem_a <= '{1'b1, 8'h70};
		dem_b <= '{1'b1, 8'h70};
		dem_c <= '{1'b1, 8'h70};
		dem_d <= '{1'b1, 8'h70};
		for (int f = 0; f < 4; f++) begin
			wr(`IDX_CD_CFG, 8'h90 | f[7:0]);
			rd(`IDX_DUTY_CD);
			`CHK(rv[15:0], {(f[1] ? 8'h46 : 8'h00), (f[0] ? 8'h35 : 8'h00)})
			rd(`IDX_DUTY_AB);
			`CHK(rv[15:0], 16'h0000)
		end
	endtask
	// software reset restores defaults and manual mode; then lock refuses writes
	task automatic swrst_lock();
		wr(`IDX_CTRL, 8'h04);
		rchk(`IDX_CD_CFG, 32'h0000_0090);
		rchk(`IDX_C_MIN, 32'h0000_0080);
		rchk(`IDX_MAX_DUTY, 32'h0000_00C0);
		dem_a <= '{1'b0, 8'h10};
		rd(`IDX_DUTY_AB);
		`CHK(rv[7:0], 8'h10)
		wr(`IDX_CTRL, 8'h02);
		wr(`IDX_CD_CFG, 8'h00);
		`CHK(resp, 2'b00)
		rchk(`IDX_CD_CFG, 32'h0000_0090);
		wr(`IDX_D_MIN, 8'h11);
		rchk(`IDX_D_MIN, 32'h0000_0080);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge aclk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		aresetn = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		dem_a = '{1'b0, 8'h00};
		dem_b = '{1'b0, 8'h00};
		dem_c = '{1'b0, 8'h02};
		dem_d = '{1'b0, 8'h04};
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		pulse_width();
		reset_values();
		rate_codes();
		clamp();
		idle_floor();
		swrst_lock();
		tally_and_finish();
	end
endmodule
